// file: fbo_chk.sv
// pin-level checker for the flash bus controller
`timescale 1ns/1ps
module fbo_chk #(
   parameter int unsigned PROT_CYCLES   = 8,   // protect pulse length
   parameter int unsigned UNPROT_CYCLES = 16   // unprotect wait length
) (
   input wire logic                       mclk,                      // clock
   input wire logic                       rst_n,                     // reset, active low
   input wire logic                       req_temp_unprot,           // temporary unprotect request
   input wire logic                       rsp_valid,                 // answer pulse
   input wire logic                       busy_seen,                 // registered busy flag
   input wire logic                       chip_sel_n,                // chip select
   input wire logic                       chip_sel_hv,               // chip select elevated
   input wire logic                       out_gate_n,                // output gate
   input wire logic                       out_gate_hv,               // output gate elevated
   input wire logic                       wr_strobe_n,               // write strobe
   input wire logic                       reset_unprotect_hv,        // reset pin elevated
   input wire logic                       width_word,                // width select
   input wire logic                       signature_address_line_hv, // signature line elevated
   input wire logic [fbo_pkg::DATA_W-1:0] dq_oe_n,                   // data enables
   input wire logic                       ready_busy_n               // ready/busy pin
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   int unsigned cnt_reg, cnt_next;
   logic        urun_reg, urun_next;
   // cycles since strobe fell, held through a full unprotect until its answer
   always_comb begin
      cnt_next = (wr_strobe_n && !urun_reg) ? 0 : ((cnt_reg < 1000000) ? cnt_reg + 1 : cnt_reg);
      urun_next = rsp_valid ? 1'b0 : (urun_reg || (!wr_strobe_n && chip_sel_hv));
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 0;
         urun_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         urun_reg <= urun_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   a_write_gate_high: assert property ((!wr_strobe_n && !out_gate_hv) |-> out_gate_n)
      else $error("strobe low with gate low");
   a_write_sel_low: assert property ((!wr_strobe_n && !chip_sel_hv) |-> !chip_sel_n)
      else $error("strobe low without select");
   a_gate_frees_bus: assert property (!out_gate_n |-> &dq_oe_n)
      else $error("host drives data while gate low");
   a_gate_after_sel: assert property ($fell(out_gate_n) |-> !chip_sel_n && $past(!chip_sel_n))
      else $error("gate opened before select");
   a_prot_pulse_len: assert property ($rose(wr_strobe_n) && out_gate_hv && !chip_sel_hv |-> cnt_reg >= PROT_CYCLES)
      else $error("protect pulse too short");
   a_unprot_wait_len: assert property (rsp_valid && urun_reg |-> cnt_reg >= UNPROT_CYCLES)
      else $error("unprotect answered too early");
   a_hv_needs_sig: assert property ((out_gate_hv || chip_sel_hv) |-> signature_address_line_hv)
      else $error("elevated pin without signature line");
   a_byte_upper_free: assert property (!width_word |-> dq_oe_n[15:8] == 8'hff)
      else $error("upper lanes driven in byte mode");
   a_temp_follow: assert property ($rose(req_temp_unprot) |=> reset_unprotect_hv)
      else $error("reset pin not elevated");
   a_rsp_not_busy: assert property (rsp_valid |-> $past(ready_busy_n))
      else $error("answer while device busy");
   a_busy_mirror: assert property (busy_seen == !$past(ready_busy_n))
      else $error("busy flag does not follow pin");
   c_prot: cover property ($rose(wr_strobe_n) && out_gate_hv);
   c_unprot: cover property (rsp_valid && urun_reg);
   c_byte_read: cover property ($fell(out_gate_n) && !width_word);
endmodule
bind fbo_host fbo_chk #(.PROT_CYCLES(PROT_CYCLES), .UNPROT_CYCLES(UNPROT_CYCLES)) u_chk (.mclk, .rst_n,
   .req_temp_unprot, .rsp_valid, .busy_seen, .chip_sel_n, .chip_sel_hv, .out_gate_n, .out_gate_hv, .wr_strobe_n,
   .reset_unprotect_hv, .width_word, .signature_address_line_hv, .dq_oe_n, .ready_busy_n);

// file: fbo_flash_model.sv
// behavioural flash device on the controller's pins
`timescale 1ns/1ps
module fbo_flash_model #(
   parameter int         PROT_NS   = 150,    // shortened protect pulse
   parameter int         UNPROT_NS = 300,    // shortened unprotect time
   parameter logic [7:0] MAKER     = 8'h3c,  // arbitrary value
   parameter logic [7:0] PART      = 8'h96   // arbitrary value
) (
   input wire logic        chip_sel_n,                // chip select
   input wire logic        chip_sel_hv,               // select elevated
   input wire logic        out_gate_n,                // output gate
   input wire logic        out_gate_hv,               // gate elevated
   input wire logic        wr_strobe_n,               // write strobe
   input wire logic        reset_unprotect_n,         // reset pin
   input wire logic        reset_unprotect_hv,        // reset elevated
   input wire logic        width_word,                // width select
   input wire logic        signature_address_line_hv, // signature line elevated
   input wire logic [18:0] addr,                      // address pins
   input wire logic [15:0] dq_o,                      // host data
   input wire logic [15:0] dq_oe_n,                   // host enables
   output logic [15:0]     dq_i,                      // resolved data wire
   output logic            ready_busy_n               // ready/busy
);
   logic [15:0]  mem [int];
   logic [127:0] prot = '0;
   logic [15:0]  rd;
   logic [15:0]  last = '0;
   logic [18:0]  a_lat;
   logic         wr_act = 1'b0;
   logic         wtog = 1'b0;
   realtime      t_fall;
   wire          sig = signature_address_line_hv;
   wire          drv = !chip_sel_n && !out_gate_n && reset_unprotect_n;
   // read source: array, codes or protect status; erased reads ffff
   always @(addr, sig, prot, wtog) begin
      if (!sig)
         rd = mem.exists(addr) ? mem[addr] : 16'hffff;
      else if (!addr[1])
         rd = {8'h00, addr[0] ? PART : MAKER};
      else
         rd = {15'h0000, prot[addr[18:12]]};
   end
   // wire level; a released line shows the inverse of the device's last read data
   always @*
      for (int i = 0; i < 16; i++)
         dq_i[i] = !dq_oe_n[i] ? dq_o[i] : (drv && (width_word || i < 8)) ? rd[i] : ~last[i];
   always @(negedge drv) last = rd;
   // address at the later falling edge, data at the earlier rising edge
   always @(negedge wr_strobe_n or negedge chip_sel_n)
      if (!wr_strobe_n && !chip_sel_n && out_gate_n && !sig) begin
         wr_act = 1'b1;
         a_lat = addr;
      end
   always @(posedge wr_strobe_n or posedge chip_sel_n)
      if (wr_act) begin
         wr_act = 1'b0;
         if (!prot[a_lat[18:12]] || reset_unprotect_hv) begin
            mem[a_lat] = width_word ? dq_i : {8'hff, dq_i[7:0]};
            wtog = ~wtog;
         end
         ready_busy_n = 1'b0;
         ready_busy_n <= #200 1'b1;
      end
   initial ready_busy_n = 1'b1;
   // protect needs the full pulse; unprotect clears all after its delay
   always @(negedge wr_strobe_n)
      if (sig && out_gate_hv) begin
         t_fall = $realtime;
         if (chip_sel_hv && addr[12] && addr[15])
            prot <= #(UNPROT_NS) '0;
      end
   always @(posedge wr_strobe_n)
      if (sig && out_gate_hv && !chip_sel_hv && $realtime - t_fall >= PROT_NS)
         prot[addr[18:12]] = 1'b1;
endmodule

// file: fbo_host.sv
// host controller driving the flash bus pins
// Functional notes
// - read data only while select and gate low
// - host writes with select, strobe low, gate high
// - protect: strobe low 100us, gate elevated
// - protect every block before full unprotection
// - unprotect verify returns 00h, each block
`timescale 1ns/1ps
module fbo_host #(
   parameter int unsigned PROT_CYCLES   = fbo_pkg::PROT_CYC,   // protect pulse length
   parameter int unsigned UNPROT_CYCLES = fbo_pkg::UNPROT_CYC  // unprotect wait length
) (
   input  wire logic                        mclk,             // system clock
   input  wire logic                        rst_n,            // async reset, active low
   input  wire logic                        req_valid,        // request strobe, one cycle
   input  wire fbo_pkg::fbo_op_t            req_op,           // operation kind
   input  wire logic [fbo_pkg::ADDR_W-1:0]  req_addr,         // word address
   input  wire logic [fbo_pkg::DATA_W-1:0]  req_wdata,        // write data
   input  wire logic                        req_byte,         // 1 = byte mode
   input  wire logic                        req_temp_unprot,  // hold reset input elevated
   output logic                             req_ready,        // idle, can take request
   output logic                             rsp_valid,        // answer pulse
   output logic [fbo_pkg::DATA_W-1:0]       rsp_rdata,        // read data
   output logic                             rsp_protected,    // verify found block protected
   output logic                             busy_seen,        // ready/busy pin low
   output logic                             chip_sel_n,       // chip select pin
   output logic                             chip_sel_hv,      // chip select elevated qualifier
   output logic                             out_gate_n,       // output gate pin
   output logic                             out_gate_hv,      // output gate elevated qualifier
   output logic                             wr_strobe_n,      // write strobe pin
   output logic                             reset_unprotect_n,// reset pin
   output logic                             reset_unprotect_hv, // reset elevated qualifier
   output logic                             width_word,       // width select, 1 = word
   output logic                             signature_address_line_hv, // signature line elevated
   output logic [fbo_pkg::ADDR_W-1:0]       addr,             // address pins
   output logic [fbo_pkg::DATA_W-1:0]       dq_o,             // data pins out
   output logic [fbo_pkg::DATA_W-1:0]       dq_oe_n,          // data enable, low drives
   input  wire logic [fbo_pkg::DATA_W-1:0]  dq_i,             // data pins in
   input  wire logic                        ready_busy_n      // ready/busy pin
);
   typedef enum {ST_IDLE, ST_SETUP, ST_ACT, ST_HOLD, ST_WAIT} fbo_state_t;

   fbo_timer_if tif ();
   fbo_timer u_timer (
      .mclk  (mclk),
      .rst_n (rst_n),
      .tif   (tif)
   );

   ////////////////////////////////////////////////////////////////////////////////
   fbo_state_t                 st_reg, st_next;
   fbo_pkg::fbo_op_t           op_reg, op_next;
   logic                       ce_reg, ce_next, ceh_reg, ceh_next;
   logic                       oe_reg, oe_next, oeh_reg, oeh_next;
   logic                       we_reg, we_next, rph_reg, rph_next;
   logic                       byte_reg, byte_next, sig_reg, sig_next;
   logic [fbo_pkg::ADDR_W-1:0] a_reg, a_next;
   logic [fbo_pkg::DATA_W-1:0] d_reg, d_next, dz_reg, dz_next;
   logic [fbo_pkg::DATA_W-1:0] rd_reg, rd_next;
   logic                       rv_reg, rv_next, pr_reg, pr_next, bsy_reg;
   logic                       rdy_reg, rdy_next, rpn_reg, rpn_next;

   // address pins for a signature/verify/unprotect operation: qualifier bits forced
   function automatic logic [fbo_pkg::ADDR_W-1:0] mode_addr(input fbo_pkg::fbo_op_t op,
                                                            input logic [fbo_pkg::ADDR_W-1:0] a);
      logic [fbo_pkg::ADDR_W-1:0] r;
      r = a;
      unique case (op)
         fbo_pkg::FBO_OP_SIG: r[fbo_pkg::BIT_A1] = 1'b0;
         fbo_pkg::FBO_OP_PVERIFY: begin
            r[fbo_pkg::BIT_A0] = 1'b0;
            r[fbo_pkg::BIT_A1] = 1'b1;
            r[fbo_pkg::BIT_A6] = 1'b0;
         end
         fbo_pkg::FBO_OP_UVERIFY: begin
            r[fbo_pkg::BIT_A0] = 1'b0;
            r[fbo_pkg::BIT_A1] = 1'b1;
            r[fbo_pkg::BIT_A6] = 1'b1;
         end
         fbo_pkg::FBO_OP_UNPROT: begin
            r[fbo_pkg::BIT_A12] = 1'b1;
            r[fbo_pkg::BIT_A15] = 1'b1;
         end
         default: r = a;
      endcase
      return r;
   endfunction

   // sequencer: drives pins phase by phase, timer sets phase length
   always_comb begin
      st_next = st_reg;    op_next = op_reg;
      ce_next = ce_reg;    ceh_next = ceh_reg;
      oe_next = oe_reg;    oeh_next = oeh_reg;
      we_next = we_reg;    rph_next = req_temp_unprot;
      byte_next = byte_reg; sig_next = sig_reg;
      a_next = a_reg;      d_next = d_reg;  dz_next = dz_reg;
      rd_next = rd_reg;    rv_next = 1'b0;  pr_next = pr_reg;
      rpn_next = 1'b1;                                                  // device out of reset once running
      tif.start = 1'b0;
      tif.load  = '0;
      unique case (st_reg)
         ST_IDLE: begin
            if (req_valid) begin
               op_next   = req_op;
               byte_next = req_byte;
               a_next    = mode_addr(req_op, req_addr);
               d_next    = req_wdata;
               sig_next  = (req_op != fbo_pkg::FBO_OP_READ) && (req_op != fbo_pkg::FBO_OP_WRITE);
               ce_next   = (req_op != fbo_pkg::FBO_OP_UNPROT);          // select low by default
               ceh_next  = (req_op == fbo_pkg::FBO_OP_UNPROT);
               ce_next   = !ce_next;
               oeh_next  = (req_op == fbo_pkg::FBO_OP_PROT) || (req_op == fbo_pkg::FBO_OP_UNPROT);
               oe_next   = 1'b1;                                        // gate high while setting up
               tif.start = 1'b1;
               tif.load  = fbo_pkg::CNT_W'(fbo_pkg::SETUP_CYC);
               st_next   = ST_SETUP;
            end
         end
         ST_SETUP: if (tif.done) begin
            tif.start = 1'b1;
            unique case (op_reg)
               fbo_pkg::FBO_OP_WRITE: begin
                  we_next  = 1'b0;
                  dz_next  = byte_reg ? 16'hff00 : 16'h0000;            // byte mode drives low lanes only, word mode all
                  tif.load = fbo_pkg::CNT_W'(fbo_pkg::ACCESS_CYC);
               end
               fbo_pkg::FBO_OP_PROT: begin
                  we_next  = 1'b0;
                  tif.load = fbo_pkg::CNT_W'(PROT_CYCLES);
               end
               fbo_pkg::FBO_OP_UNPROT: begin
                  we_next  = 1'b0;
                  tif.load = fbo_pkg::CNT_W'(UNPROT_CYCLES);
               end
               default: begin
                  oe_next  = 1'b0;
                  tif.load = fbo_pkg::CNT_W'(fbo_pkg::ACCESS_CYC);    // address held steady
               end
            endcase
            st_next = ST_ACT;
         end
         ST_ACT: if (tif.done) begin
            if (!oe_reg) begin
               rd_next = byte_reg ? {8'h00, dq_i[7:0]} : dq_i;
               pr_next = (dq_i[7:0] == fbo_pkg::PROT_YES);
            end
            we_next  = 1'b1;                                            // data taken at rise
            oe_next  = 1'b1;
            tif.start = 1'b1;
            tif.load  = fbo_pkg::CNT_W'(fbo_pkg::SETUP_CYC);
            st_next   = ST_HOLD;
         end
         ST_HOLD: if (tif.done) begin
            ce_next  = 1'b1;
            ceh_next = 1'b0;
            oeh_next = 1'b0;
            sig_next = 1'b0;
            dz_next  = 16'hffff;
            st_next  = ST_WAIT;
         end
         ST_WAIT: if (bsy_reg == 1'b0) begin
            rv_next = 1'b1;
            st_next = ST_IDLE;
         end
         default: st_next = ST_IDLE;
      endcase
      rdy_next = (st_next == ST_IDLE);                                  // ready flag registered with state
   end

   // register all pin and status state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= ST_IDLE;   op_reg <= fbo_pkg::FBO_OP_READ;
         ce_reg <= 1'b1;      ceh_reg <= 1'b0;
         oe_reg <= 1'b1;      oeh_reg <= 1'b0;
         we_reg <= 1'b1;      rph_reg <= 1'b0;
         byte_reg <= 1'b0;    sig_reg <= 1'b0;
         a_reg <= '0;         d_reg <= '0;     dz_reg <= 16'hffff;
         rd_reg <= '0;        rv_reg <= 1'b0;  pr_reg <= 1'b0;
         bsy_reg <= 1'b0;
         rdy_reg <= 1'b1;     rpn_reg <= 1'b0;                          // device held in reset
      end else begin
         st_reg <= st_next;   op_reg <= op_next;
         ce_reg <= ce_next;   ceh_reg <= ceh_next;
         oe_reg <= oe_next;   oeh_reg <= oeh_next;
         we_reg <= we_next;   rph_reg <= rph_next;
         byte_reg <= byte_next; sig_reg <= sig_next;
         a_reg <= a_next;     d_reg <= d_next;  dz_reg <= dz_next;
         rd_reg <= rd_next;   rv_reg <= rv_next; pr_reg <= pr_next;
         bsy_reg <= !ready_busy_n;
         rdy_reg <= rdy_next; rpn_reg <= rpn_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin outputs straight from flip-flops
   assign req_ready                 = rdy_reg;
   assign rsp_valid                 = rv_reg;
   assign rsp_rdata                 = rd_reg;
   assign rsp_protected             = pr_reg;
   assign busy_seen                 = bsy_reg;
   assign chip_sel_n                = ce_reg;
   assign chip_sel_hv               = ceh_reg;
   assign out_gate_n                = oe_reg;
   assign out_gate_hv               = oeh_reg;
   assign wr_strobe_n               = we_reg;
   assign reset_unprotect_n         = rpn_reg;
   assign reset_unprotect_hv        = rph_reg;
   assign width_word                = !byte_reg;
   assign signature_address_line_hv = sig_reg;
   assign addr                      = a_reg;
   assign dq_o                      = d_reg;
   assign dq_oe_n                   = dz_reg;
endmodule

// file: fbo_pkg.sv
// package with pin-level constants for the flash bus controller
package fbo_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 20;
   localparam int unsigned PROT_PULSE_US   = 100;
   localparam int unsigned UNPROT_PULSE_MS = 10;
   localparam int unsigned ACCESS_NS       = 80;
   localparam int unsigned ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PROT_CYC        = (PROT_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned UNPROT_CYC      = (UNPROT_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETUP_CYC       = 2;
   localparam int unsigned ADDR_W          = 19;
   localparam int unsigned DATA_W          = 16;
   localparam int unsigned CNT_W           = 20;
   localparam int unsigned BIT_A0          = 0;
   localparam int unsigned BIT_A1          = 1;
   localparam int unsigned BIT_A6          = 6;
   localparam int unsigned BIT_A12         = 12;
   localparam int unsigned BIT_A15         = 15;
   localparam int unsigned BLK_LSB         = 12;
   localparam logic [7:0]  PROT_YES        = 8'h01;
   localparam logic [7:0]  PROT_NO         = 8'h00;
   typedef enum logic [2:0] {
      FBO_OP_READ, FBO_OP_WRITE, FBO_OP_SIG, FBO_OP_PROT, FBO_OP_PVERIFY, FBO_OP_UNPROT, FBO_OP_UVERIFY
   } fbo_op_t;
endpackage

// file: fbo_timer.sv
// down counter timing bus phases and protection pulses
`timescale 1ns/1ps
module fbo_timer (
   input  wire logic mclk,        // system clock
   input  wire logic rst_n,       // async reset, active low
   fbo_timer_if.timer tif         // start, load value, done
);
   logic [fbo_pkg::CNT_W-1:0] cnt_reg;
   logic [fbo_pkg::CNT_W-1:0] cnt_next;
   logic                      done_reg;
   logic                      done_next;

   // next count: load on start, then count to zero and flag once
   always_comb begin
      cnt_next  = cnt_reg;
      done_next = 1'b0;
      if (tif.start) begin
         cnt_next = tif.load;
      end else if (cnt_reg != '0) begin
         cnt_next  = cnt_reg - 1'b1;
         done_next = (cnt_reg == fbo_pkg::CNT_W'(1));
      end
   end

   // register the counter
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg  <= '0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign tif.done = done_reg;
endmodule

// file: fbo_timer_if.sv
// interface between the sequencer and its pulse timer
`timescale 1ns/1ps
interface fbo_timer_if;
   logic                       start;
   logic [fbo_pkg::CNT_W-1:0]  load;
   logic                       done;
   modport master (output start, output load, input done);
   modport timer  (input start, input load, output done);
endinterface

// file: tb.sv
// self-checking bench for the flash bus controller
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
   localparam logic [7:0] PART  = 8'h96; // arbitrary value
   logic mclk = 0, rst_n = 0, req_valid = 0, req_byte = 0, req_temp_unprot = 0;
   fbo_pkg::fbo_op_t req_op = fbo_pkg::FBO_OP_READ;
   logic [18:0] req_addr = '0, addr;
   logic [15:0] req_wdata = '0, rsp_rdata, dq_o, dq_oe_n, dq_i, rd;
   logic req_ready, rsp_valid, rsp_protected, busy_seen, chip_sel_n, chip_sel_hv, out_gate_n, out_gate_hv;
   logic wr_strobe_n, reset_unprotect_n, reset_unprotect_hv, width_word, signature_address_line_hv, ready_busy_n;
   int err_count = 0, n_compared = 0, cyc = 0;
   fbo_host #(.PROT_CYCLES(8), .UNPROT_CYCLES(16)) dut (.mclk, .rst_n, .req_valid, .req_op, .req_addr,
      .req_wdata, .req_byte, .req_temp_unprot, .req_ready, .rsp_valid, .rsp_rdata, .rsp_protected, .busy_seen,
      .chip_sel_n, .chip_sel_hv, .out_gate_n, .out_gate_hv, .wr_strobe_n, .reset_unprotect_n, .reset_unprotect_hv,
      .width_word, .signature_address_line_hv, .addr, .dq_o, .dq_oe_n, .dq_i, .ready_busy_n);
   fbo_flash_model #(.MAKER(MAKER), .PART(PART)) flash (.chip_sel_n, .chip_sel_hv, .out_gate_n, .out_gate_hv,
      .wr_strobe_n, .reset_unprotect_n, .reset_unprotect_hv, .width_word, .signature_address_line_hv, .addr,
      .dq_o, .dq_oe_n, .dq_i, .ready_busy_n);
   initial forever #10 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one request, waiting for ready and then for the answer
   task automatic req(input fbo_pkg::fbo_op_t op, input logic [18:0] a, input logic [15:0] d, input logic b);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 1000) begin
         @(posedge mclk);
         #1 n++;
      end
      req_valid = 1;
      req_op = op;
      req_addr = a;
      req_wdata = d;
      req_byte = b;
      @(posedge mclk);
      #1 req_valid = 0;
      while (rsp_valid !== 1'b1 && n < 2000) begin
         @(posedge mclk);
         #1 n++;
      end
      if (n >= 1000)
         err_count++;
      rd = rsp_rdata;
   endtask
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_write_read();
      req(fbo_pkg::FBO_OP_WRITE, 19'h00005, 16'ha55a, 0);
      req(fbo_pkg::FBO_OP_WRITE, 19'h00006, 16'h1234, 0);
      req(fbo_pkg::FBO_OP_READ, 19'h00005, 16'h0000, 0);
      check(rd, 16'ha55a);
      req(fbo_pkg::FBO_OP_READ, 19'h00006, 16'h0000, 0);
      check(rd, 16'h1234);
      req(fbo_pkg::FBO_OP_READ, 19'h00007, 16'h0000, 0);
      check(rd, 16'hffff);
      req(fbo_pkg::FBO_OP_WRITE, 19'h00008, 16'h5a77, 1);
      req(fbo_pkg::FBO_OP_READ, 19'h00008, 16'h0000, 1);
      check(rd, 16'h0077);
   endtask
   task automatic t_signature();
      req(fbo_pkg::FBO_OP_SIG, 19'h7fffc, 16'h0000, 0);
      check(rd, {8'h00, MAKER});
      req(fbo_pkg::FBO_OP_SIG, 19'h00001, 16'h0000, 0);
      check(rd, {8'h00, PART});
      req(fbo_pkg::FBO_OP_SIG, 19'h00000, 16'h0000, 1);
      check(rd, {8'h00, MAKER});
   endtask
   task automatic t_protect();
      for (int b = 0; b < 128; b++)
         req(fbo_pkg::FBO_OP_PROT, {b[6:0], 12'h000}, 16'h0000, 0);
      req(fbo_pkg::FBO_OP_PVERIFY, 19'h05002, 16'h0000, 0);
      check(rd, 16'h0001);
      check({15'h0000, rsp_protected}, 16'h0001);
      req(fbo_pkg::FBO_OP_WRITE, 19'h05010, 16'h0bad, 0);
      req(fbo_pkg::FBO_OP_READ, 19'h05010, 16'h0000, 0);
      check(rd, 16'hffff);
      req_temp_unprot = 1;
      req(fbo_pkg::FBO_OP_WRITE, 19'h05010, 16'hbeef, 0);
      req_temp_unprot = 0;
      req(fbo_pkg::FBO_OP_READ, 19'h05010, 16'h0000, 0);
      check(rd, 16'hbeef);
   endtask
   task automatic t_unprot();
      req(fbo_pkg::FBO_OP_UNPROT, 19'h09000, 16'h0000, 0);
      for (int b = 0; b < 128; b++) begin
         req(fbo_pkg::FBO_OP_UVERIFY, {b[6:0], 12'h042}, 16'h0000, 0);
         check(rd, 16'h0000);
         check({15'h0000, rsp_protected}, 16'h0000);
      end
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (16) @(posedge mclk);
      #1 rst_n = 1;
      t_write_read();
      t_signature();
      t_protect();
      t_unprot();
      end_of_test();
   end
endmodule
